/* File: periodic_tick_timer_defs.svh */
`ifndef PERIODIC_TICK_TIMER_DEFS_SVH
`define PERIODIC_TICK_TIMER_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MODE_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define ACK_VALUE_OFFSET 8'h08
`define IMAGE_VALUE_OFFSET 8'h0c
`define EVENT_STATUS_OFFSET 8'h10
`define EVENT_MASK_OFFSET 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define COUNT_WIDTH 20
`define TALLY_WIDTH 12
`define LIMIT_LSB 0
`define LIMIT_MSB 19
`define TIMER_ENABLE_BIT 24
`define IRQ_ENABLE_BIT 25
`define FLAG_BIT 0
`define COUNT_LSB 0
`define COUNT_MSB 19
`define TALLY_LSB 20
`define TALLY_MSB 31
`define EVENT_WIDTH 2
`define EVENT_REACHED_BIT 0
`define EVENT_WRAP_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LIMIT_RESET 20'hfffff
`define EVENT_MASK_RESET 2'h0

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define PRESCALE_DIV 16
`define PRESCALE_WIDTH 4

`endif

/* File: tick_timer_pkg.sv */
`include "periodic_tick_timer_defs.svh"

package tick_timer_pkg;

  // ----------------------------------------
  // Bus answer phase
  // ----------------------------------------
  typedef enum logic {
    bus_capture = 1'b0,
    bus_answer = 1'b1
  } bus_phase_e;

  // ----------------------------------------
  // Timer state
  // ----------------------------------------
  typedef struct packed {
    logic [`COUNT_WIDTH-1:0] interval_count;
    logic [`TALLY_WIDTH-1:0] overflow_tally;
    logic [`COUNT_WIDTH-1:0] interval_limit;
    logic timer_enable_bit;
    logic tick_irq_enable;
    logic running;
    logic interval_reached_flag;
    logic [`EVENT_WIDTH-1:0] event_status;
    logic [`EVENT_WIDTH-1:0] event_mask;
    logic [`TALLY_WIDTH-1:0] captured_tally;
    logic [31:0] rdata;
    bus_phase_e phase;
  } timer_state_s;

endpackage

/* File: tick_prescaler.sv */
`timescale 1ns/1ns
`include "periodic_tick_timer_defs.svh"

module tick_prescaler #(
  parameter int unsigned DIV = `PRESCALE_DIV,
  parameter int unsigned W = `PRESCALE_WIDTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic hold,
  // Divided enable
  output logic tick
);

  typedef struct packed {
    logic [W-1:0] div;
  } prescale_state_s;

  prescale_state_s state;
  prescale_state_s next_state;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  assign tick = !hold && (state.div == W'(DIV - 1));

  always_comb
  begin
    next_state = state;
    if (!hold)
    begin
      if (state.div == W'(DIV - 1))
        next_state.div = '0;
      else
        next_state.div = state.div + W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state <= '{div: '0};
    else
      state <= next_state;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_tick_spacing: assert property (@(posedge clk) disable iff (reset) tick |=> !tick [*8])
    else $error("divided enable came too soon");

  a_halt_no_tick: assert property (@(posedge clk) disable iff (reset) hold |-> !tick)
    else $error("divided enable during halt");

endmodule

/* File: periodic_tick_timer.sv */
`timescale 1ns/1ns
`include "periodic_tick_timer_defs.svh"

// Operation
// - Twenty-bit interval count, twelve-bit overflow tally
// - Both counters advance on clock divided by sixteen
// - Count up; at limit wrap, bump tally
// - Limit sets flag; flag interrupts when enabled
// - New limit never restarts the counters
// - Acknowledge read returns counts, clears tally, flag
// - Tally counts intervals since last acknowledge
// - Image read returns counts without side effects
// - Enable bit in mode, disabled after reset
// - Enable change takes effect at count zero
// - Disabled timer finishes interval, then holds zero
// - Debug halt freezes both counters
// - Period is limit plus one ticks
module periodic_tick_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state
  input wire logic debug_halt,
  // Interrupt
  output logic irq
);

  tick_timer_pkg::timer_state_s state;
  tick_timer_pkg::timer_state_s next_state;

  logic tick;
  logic [31:0] lane_mask;
  logic addr_hit;
  logic done;
  logic wr_done;
  logic rd_done;
  logic run;
  logic reached;
  logic wrap;
  logic ack_read;
  logic image_read;
  logic [31:0] mode_word;
  logic [31:0] value_word;
  logic [31:0] read_word;
  logic [31:0] merged_mode;
  logic [31:0] merged_mask;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  tick_prescaler #(
    .DIV(`PRESCALE_DIV),
    .W(`PRESCALE_WIDTH)
  ) u_prescaler (
    .clk(clk),
    .reset(reset),
    .hold(debug_halt),
    .tick(tick)
  );

  // ----------------------------------------
  // Byte lanes
  // ----------------------------------------
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      assign lane_mask[8*lane +: 8] = {8{pstrb[lane]}};
    end
  endgenerate

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  always_comb
  begin
    case (paddr)
      `MODE_OFFSET,
      `STATUS_OFFSET,
      `ACK_VALUE_OFFSET,
      `IMAGE_VALUE_OFFSET,
      `EVENT_STATUS_OFFSET,
      `EVENT_MASK_OFFSET: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pready = psel && penable && (state.phase == tick_timer_pkg::bus_answer);
  assign pslverr = pready && !addr_hit;
  assign done = pready;
  assign wr_done = done && pwrite && addr_hit;
  assign rd_done = done && !pwrite && addr_hit;
  assign ack_read = rd_done && (paddr == `ACK_VALUE_OFFSET);
  assign image_read = rd_done && (paddr == `IMAGE_VALUE_OFFSET);
  assign prdata = state.rdata;

  // ----------------------------------------
  // Register images
  // ----------------------------------------
  always_comb
  begin
    mode_word = 32'h00000000;
    mode_word[`LIMIT_MSB:`LIMIT_LSB] = state.interval_limit;
    mode_word[`TIMER_ENABLE_BIT] = state.timer_enable_bit;
    mode_word[`IRQ_ENABLE_BIT] = state.tick_irq_enable;
    value_word = 32'h00000000;
    value_word[`TALLY_MSB:`TALLY_LSB] = state.overflow_tally;
    value_word[`COUNT_MSB:`COUNT_LSB] = state.interval_count;
    merged_mode = (pwdata & lane_mask) | (mode_word & ~lane_mask);
    merged_mask = (pwdata & lane_mask) | ({30'h00000000, state.event_mask} & ~lane_mask);
  end

  always_comb
  begin
    read_word = 32'h00000000;
    case (paddr)
      `MODE_OFFSET: read_word = mode_word;
      `STATUS_OFFSET: read_word[`FLAG_BIT] = state.interval_reached_flag;
      `ACK_VALUE_OFFSET: read_word = value_word;
      `IMAGE_VALUE_OFFSET: read_word = value_word;
      `EVENT_STATUS_OFFSET: read_word[`EVENT_WIDTH-1:0] = state.event_status;
      `EVENT_MASK_OFFSET: read_word[`EVENT_WIDTH-1:0] = state.event_mask;
      default: read_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Counting
  // ----------------------------------------
  always_comb
  begin
    run = state.running;
    if (state.interval_count == `COUNT_WIDTH'(0))
      run = state.timer_enable_bit;
    reached = tick && run && (state.interval_count == state.interval_limit);
    wrap = reached && (state.overflow_tally == {`TALLY_WIDTH{1'b1}});
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;

    // Interval counter
    if (tick)
    begin
      next_state.running = run;
      if (run)
      begin
        if (reached)
          next_state.interval_count = `COUNT_WIDTH'(0);
        else
          next_state.interval_count = state.interval_count + `COUNT_WIDTH'(1);
      end
    end

    // Overflow tally, less what an acknowledge already returned
    if (ack_read)
      next_state.overflow_tally = state.overflow_tally - state.captured_tally;
    if (reached)
      next_state.overflow_tally = next_state.overflow_tally + `TALLY_WIDTH'(1);

    // Reached flag, a new event wins over the acknowledge
    if (ack_read)
      next_state.interval_reached_flag = reached || (next_state.overflow_tally != `TALLY_WIDTH'(0));
    else if (reached)
      next_state.interval_reached_flag = 1'b1;

    // Sticky events, cleared on read of the bits returned
    if (rd_done && (paddr == `EVENT_STATUS_OFFSET))
      next_state.event_status = state.event_status & ~state.rdata[`EVENT_WIDTH-1:0];
    if (reached)
      next_state.event_status[`EVENT_REACHED_BIT] = 1'b1;
    if (wrap)
      next_state.event_status[`EVENT_WRAP_BIT] = 1'b1;

    // Register writes
    if (wr_done && (paddr == `MODE_OFFSET))
    begin
      next_state.interval_limit = merged_mode[`LIMIT_MSB:`LIMIT_LSB];
      next_state.timer_enable_bit = merged_mode[`TIMER_ENABLE_BIT];
      next_state.tick_irq_enable = merged_mode[`IRQ_ENABLE_BIT];
    end
    if (wr_done && (paddr == `EVENT_MASK_OFFSET))
      next_state.event_mask = merged_mask[`EVENT_WIDTH-1:0];

    // Bus answer, one wait cycle in the access phase
    case (state.phase)
      tick_timer_pkg::bus_capture:
      begin
        if (psel && penable)
        begin
          next_state.rdata = pwrite ? 32'h00000000 : read_word;
          next_state.captured_tally = state.overflow_tally;
          next_state.phase = tick_timer_pkg::bus_answer;
        end
      end
      tick_timer_pkg::bus_answer:
      begin
        next_state.phase = tick_timer_pkg::bus_capture;
      end
      default:
      begin
        next_state.phase = tick_timer_pkg::bus_capture;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state.interval_count <= `COUNT_WIDTH'(0);
      state.overflow_tally <= `TALLY_WIDTH'(0);
      state.interval_limit <= `LIMIT_RESET;
      state.timer_enable_bit <= 1'b0;
      state.tick_irq_enable <= 1'b0;
      state.running <= 1'b0;
      state.interval_reached_flag <= 1'b0;
      state.event_status <= `EVENT_WIDTH'(0);
      state.event_mask <= `EVENT_MASK_RESET;
      state.captured_tally <= `TALLY_WIDTH'(0);
      state.rdata <= 32'h00000000;
      state.phase <= tick_timer_pkg::bus_capture;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  assign irq = (state.interval_reached_flag && state.tick_irq_enable) || (|(state.event_status & state.event_mask));

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_width_fixed: assert property (@(posedge clk) disable iff (reset)
    (tick && run && state.interval_count == {`COUNT_WIDTH{1'b1}} && state.interval_limit == {`COUNT_WIDTH{1'b1}})
    |=> state.interval_count == `COUNT_WIDTH'(0))
    else $error("interval count did not wrap at full width");

  a_count_wrap: assert property (@(posedge clk) disable iff (reset)
    (reached && !ack_read) |=> (state.interval_count == `COUNT_WIDTH'(0))
    && (state.overflow_tally == $past(state.overflow_tally) + `TALLY_WIDTH'(1)))
    else $error("limit did not wrap count and bump tally");

  a_count_step: assert property (@(posedge clk) disable iff (reset)
    (tick && run && state.interval_count != state.interval_limit)
    |=> state.interval_count == $past(state.interval_count) + `COUNT_WIDTH'(1))
    else $error("interval count did not step by one");

  a_idle_hold: assert property (@(posedge clk) disable iff (reset)
    !tick |=> $stable(state.interval_count))
    else $error("interval count moved without divided enable");

  a_flag_irq: assert property (@(posedge clk) disable iff (reset)
    (reached && state.tick_irq_enable && !(wr_done && paddr == `MODE_OFFSET))
    |=> state.interval_reached_flag && irq)
    else $error("reached flag or interrupt missing");

  a_irq_level: assert property (@(posedge clk) disable iff (reset)
    (state.interval_reached_flag && state.tick_irq_enable) |-> irq)
    else $error("enabled flag did not raise interrupt");

  a_status_read: assert property (@(posedge clk) disable iff (reset)
    (psel && penable && !pwrite && paddr == `STATUS_OFFSET && state.phase == tick_timer_pkg::bus_capture)
    |=> prdata == {31'h00000000, $past(state.interval_reached_flag)})
    else $error("status read returned wrong flag");

  a_irq_masked: assert property (@(posedge clk) disable iff (reset)
    (!state.tick_irq_enable && state.event_mask == `EVENT_WIDTH'(0)) |-> !irq)
    else $error("interrupt while disabled");

  a_limit_write: assert property (@(posedge clk) disable iff (reset)
    (wr_done && paddr == `MODE_OFFSET && !tick) |=> $stable(state.interval_count) && $stable(state.overflow_tally))
    else $error("limit write disturbed the counters");

  a_ack_clear: assert property (@(posedge clk) disable iff (reset)
    (ack_read && !reached && state.captured_tally == state.overflow_tally)
    |=> state.overflow_tally == `TALLY_WIDTH'(0) && !state.interval_reached_flag)
    else $error("acknowledge read did not clear tally and flag");

  a_ack_value: assert property (@(posedge clk) disable iff (reset)
    (psel && penable && !pwrite && paddr == `ACK_VALUE_OFFSET && state.phase == tick_timer_pkg::bus_capture)
    |=> prdata[`TALLY_MSB:`TALLY_LSB] == $past(state.overflow_tally)
    && prdata[`COUNT_MSB:`COUNT_LSB] == $past(state.interval_count))
    else $error("acknowledge read returned wrong counts");

  a_image_value: assert property (@(posedge clk) disable iff (reset)
    (psel && penable && !pwrite && paddr == `IMAGE_VALUE_OFFSET && state.phase == tick_timer_pkg::bus_capture)
    |=> prdata[`TALLY_MSB:`TALLY_LSB] == $past(state.overflow_tally)
    && prdata[`COUNT_MSB:`COUNT_LSB] == $past(state.interval_count))
    else $error("image read returned wrong counts");

  a_mode_write: assert property (@(posedge clk) disable iff (reset)
    (wr_done && paddr == `MODE_OFFSET && pstrb == 4'hf)
    |=> state.interval_limit == $past(pwdata[`LIMIT_MSB:`LIMIT_LSB])
    && state.timer_enable_bit == $past(pwdata[`TIMER_ENABLE_BIT])
    && state.tick_irq_enable == $past(pwdata[`IRQ_ENABLE_BIT]))
    else $error("mode write did not land in its fields");

  a_wrap_event: assert property (@(posedge clk) disable iff (reset)
    (wrap && !ack_read)
    |=> state.overflow_tally == `TALLY_WIDTH'(0) && state.event_status[`EVENT_WRAP_BIT])
    else $error("tally wrap not seen");

  a_image_quiet: assert property (@(posedge clk) disable iff (reset)
    (image_read && !tick) |=> $stable(state.overflow_tally) && $stable(state.interval_reached_flag))
    else $error("image read changed timer state");

  a_reset_off: assert property (@(posedge clk)
    $past(reset) |-> !state.timer_enable_bit && state.interval_limit == `LIMIT_RESET)
    else $error("timer not disabled after reset");

  a_enable_zero: assert property (@(posedge clk) disable iff (reset)
    $changed(state.running) |-> $past(state.interval_count) == `COUNT_WIDTH'(0))
    else $error("enable took effect away from zero");

  a_stopped_zero: assert property (@(posedge clk) disable iff (reset)
    !state.running && state.interval_count == `COUNT_WIDTH'(0) && !state.timer_enable_bit
    |=> state.interval_count == `COUNT_WIDTH'(0))
    else $error("disabled timer left zero");

  a_halt_freeze: assert property (@(posedge clk) disable iff (reset)
    (debug_halt && !rd_done) |=> $stable(state.interval_count) && $stable(state.overflow_tally))
    else $error("counters moved in debug halt");

  a_tally_window: assert property (@(posedge clk) disable iff (reset)
    (!ack_read && !reached) |=> $stable(state.overflow_tally))
    else $error("tally changed without an interval");

endmodule

/* File: placeholder_never_used.sv */
`timescale 1ns/1ns

/* File: periodic_tick_timer_tb.sv */
`timescale 1ns/1ns

module periodic_tick_timer_tb;
  // ----------------------------------------
  // Design ports
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic debug_halt = 1'b0;
  logic irq;

  // ----------------------------------------
  // Reference state and bookkeeping
  // ----------------------------------------
  int err_total = 0;
  int checks = 0;
  int m_pre = 0;
  logic live = 1'b0;
  logic [19:0] m_cnt = 20'h0;
  logic [11:0] m_tal = 12'h0;
  logic [19:0] m_lim = 20'hfffff;
  logic m_en = 1'b0;
  logic m_ien = 1'b0;
  logic m_run = 1'b0;
  logic m_flag = 1'b0;
  logic [1:0] m_ev = 2'h0;
  logic [1:0] m_msk = 2'h0;
  logic [1:0] ev;
  logic [31:0] m_cap = 32'h0;
  logic [31:0] mv;
  logic [15:0] seed = 16'h001e;
  logic [7:0] addrs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h02};

  periodic_tick_timer DUT (
    .clk(clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .debug_halt(debug_halt),
    .irq(irq)
  );

  always #50 clk = ~clk;

  // ----------------------------------------
  // Expectation functions
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  endfunction

  function automatic logic [31:0] exp_read(input logic [7:0] a);
    case (a)
      8'h00: return {6'h0, m_ien, m_en, 4'h0, m_lim};
      8'h04: return {31'h0, m_flag};
      8'h08, 8'h0c: return {m_tal, m_cnt};
      8'h10: return {30'h0, m_ev};
      8'h14: return {30'h0, m_msk};
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic exp_irq();
    return (m_flag & m_ien) | (|(m_ev & m_msk));
  endfunction

  // ----------------------------------------
  // Reference timer
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      {m_cnt, m_tal, m_en, m_ien, m_run, m_flag, m_ev, m_msk} = '0;
      m_lim = 20'hfffff;
      m_pre = 0;
    end
    else
    begin
      ev = 2'h0;
      if (psel && penable && !pready)
        m_cap = exp_read(paddr);
      if (!debug_halt)
        m_pre = (m_pre + 1) % 16;
      if (!debug_halt && m_pre == 0)
      begin
        if (m_cnt == 20'h0)
          m_run = m_en;
        if (m_run && m_cnt == m_lim)
        begin
          ev = {m_tal == 12'hfff, 1'b1};
          m_cnt = 20'h0;
          m_tal = m_tal + 12'h1;
        end
        else if (m_run)
          m_cnt = m_cnt + 20'h1;
      end
      m_flag = m_flag | ev[0];
      if (psel && penable && pready && mapped(paddr))
      begin
        if (pwrite && paddr == 8'h00)
        begin
          mv = exp_read(8'h00);
          for (int b = 0; b < 4; b++)
            if (pstrb[b])
              mv[8*b+:8] = pwdata[8*b+:8];
          m_lim = mv[19:0];
          m_en = mv[24];
          m_ien = mv[25];
        end
        else if (pwrite && paddr == 8'h14 && pstrb[0])
          m_msk = pwdata[1:0];
        else if (!pwrite && paddr == 8'h08)
        begin
          m_tal = m_tal - m_cap[31:20];
          m_flag = (m_tal != 12'h0) || ev[0];
        end
        else if (!pwrite && paddr == 8'h10)
          m_ev = m_ev & ~m_cap[1:0];
      end
      m_ev = m_ev | ev;
    end
  end

  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  always @(negedge clk)
    if (live)
      cmp_flag(irq, exp_irq(), "irq level");

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    cmp_flag(pslverr, !mapped(a), "slave error");
    if (!w)
      cmp(prdata, m_cap, "read data");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  task end_of_test;
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    end_of_test;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    live <= 1'b1;
    foreach (addrs[i])
      rd(addrs[i]);
    apb(1'b1, 8'h08, 32'hffffffff, 4'hf);
    apb(1'b1, 8'h04, 32'hffffffff, 4'hf);
    apb(1'b1, 8'h18, 32'hffffffff, 4'hf);
    apb(1'b1, 8'h14, 32'h3, 4'hf);
    apb(1'b1, 8'h00, 32'h03000000, 4'hf);
    repeat (4097 * 16) @(posedge clk);
    rd(8'h10);
    rd(8'h0c);
    rd(8'h08);
    rd(8'h04);
    rd(8'h10);
    apb(1'b1, 8'h00, 32'h0, 4'h8);
    repeat (64) @(posedge clk);
    rd(8'h0c);
    rd(8'h00);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h00);
    for (int i = 0; i < 200; i++)
    begin
      seed = lfsr(seed);
      case (seed[2:0])
        3'd0: apb(1'b1, 8'h00, {6'h0, seed[9:8], 4'h0, 16'h0, seed[13:10]}, 4'hf);
        3'd1, 3'd2: rd(8'h08);
        3'd3: rd(8'h0c);
        3'd4: rd(8'h04);
        3'd5: rd(8'h10);
        3'd6:
        begin
          debug_halt <= seed[8];
          @(posedge clk);
        end
        default: repeat (seed[9:4]) @(posedge clk);
      endcase
    end
    debug_halt <= 1'b0;
    rd(8'h08);
    end_of_test;
  end
endmodule
